// ==== wol_map.vh ====
// Contract
// - Reset leaves every wake detector disabled.
// - Magic frame: six 0xFF then sixteen MACs.
// - Enabled magic frame drives wake low.
// - Magic detection needs control bit set.
// - Local MAC held in three registers.
// - Only received frames are examined.
// - Magic detection recorded in status register.
// - CRC over masked bytes of first 64.
// - Exact CRC match drives wake low.
// - Four independent custom frame matchers.
// - Control bits two to five enable matchers.
// - Expected CRC split low and high.
// - Four mask registers per matcher.
// - Enabled link up/down change drives wake.
// - Link change status readable by software.
// - Route fields choose indicator or irq pin.
// - Output select field shapes both pins.
// - Wake held until source enable cleared.
// - Wake output is active low.
// - Irq pin polarity follows invert bit.
`ifndef WOL_MAP_VH
`define WOL_MAP_VH
`define WOL_IDX_ROUTE 8'h02
`define WOL_IDX_CTRL 8'h10
`define WOL_IDX_MAC_LO 8'h11
`define WOL_IDX_MAC_MI 8'h12
`define WOL_IDX_MAC_HI 8'h13
`define WOL_IDX_CRC_BASE 8'h14
`define WOL_IDX_MASK_BASE 8'h1C
`define WOL_IDX_CTRL_STAT 8'h2C
`define WOL_IDX_CUST_STAT 8'h2D
`define WOL_IDX_MAGIC_STAT 8'h2E
`define WOL_IDX_RXCRC_BASE 8'h30
`define WOL_IDX_LINK_STAT 8'h50
`define WOL_IDX_MISC 8'h51
`define WOL_CTRL_LUP 0
`define WOL_CTRL_LDN 1
`define WOL_CTRL_CUST_LSB 2
`define WOL_CTRL_MAGIC 6
`define WOL_CTRL_OSEL_LSB 14
`define WOL_ROUTE_LED 0
`define WOL_ROUTE_IRQ 1
`define WOL_MISC_IRQ_INV 0
`define WOL_PRE_BYTES 3'h6
`define WOL_MAC_COPIES 7'h60
`define WOL_CUST_BYTES 7'h40
`define WOL_CRC_POLY 32'hEDB88320
`define WOL_CRC_INIT 32'hFFFFFFFF
`endif

// ==== wol_detector.v ====
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "wol_map.vh"
module wol_detector #(
  parameter NUM_CUST = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rx_valid,
  input wire rx_sof,
  input wire rx_eof,
  input wire rx_err,
  input wire [7:0] rx_data,
  input wire link_up_pin,
  output reg wake_out_on_led_pin_n,
  output reg wake_out_on_led_pin_oe,
  output reg wake_out_on_irq_pin,
  output reg wake_out_on_irq_pin_oe
);

  function [31:0] wol_crc_byte;
    input [31:0] c;
    input [7:0] d;
    integer i;
    reg [31:0] t;
    begin
      t = c ^ {24'h000000, d};
      for (i = 0; i < 8; i = i + 1) begin
        t = t[0] ? ((t >> 1) ^ `WOL_CRC_POLY) : (t >> 1);
      end
      wol_crc_byte = t;
    end
  endfunction

  function [7:0] wol_mac_byte;
    input [47:0] mac;
    input [2:0] k;
    begin
      case (k)
        3'h0: wol_mac_byte = mac[47:40];
        3'h1: wol_mac_byte = mac[39:32];
        3'h2: wol_mac_byte = mac[31:24];
        3'h3: wol_mac_byte = mac[23:16];
        3'h4: wol_mac_byte = mac[15:8];
        default: wol_mac_byte = mac[7:0];
      endcase
    end
  endfunction

  reg [15:0] ctrl_reg;
  reg [15:0] route_reg;
  reg [15:0] misc_reg;
  reg [15:0] mac_lo_reg;
  reg [15:0] mac_mi_reg;
  reg [15:0] mac_hi_reg;
  reg [15:0] crc_reg [0:2*NUM_CUST-1];
  reg [15:0] mask_reg [0:4*NUM_CUST-1];
  reg [31:0] rxcrc_reg [0:NUM_CUST-1];
  reg [NUM_CUST-1:0] cust_pend_reg;
  reg magic_pend_reg;
  reg lup_pend_reg;
  reg ldn_pend_reg;
  reg link_s1_reg;
  reg link_s2_reg;
  reg link_s3_reg;
  reg [2:0] ff_cnt_reg;
  reg [6:0] mac_idx_reg;
  reg [2:0] mac_pos_reg;
  reg magic_hit_reg;
  reg [6:0] byte_cnt_reg;
  reg [31:0] crc_acc_reg [0:NUM_CUST-1];
  reg [31:0] rdata_next;
  reg hit_next;
  reg [7:0] ridx;
  wire [7:0] idx;
  wire [47:0] mac;
  wire setup_rd;
  wire wr_acc;
  wire mapped;
  wire [6:0] cur_cnt;
  wire any_pend;

  assign idx = paddr[9:2];
  assign mac = {mac_hi_reg, mac_mi_reg, mac_lo_reg};
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_acc = psel & penable & pwrite;
  assign pready = 1'b1;
  assign cur_cnt = rx_sof ? 7'h00 : byte_cnt_reg;

  // Address decode and read mux.
  always @* begin
    rdata_next = 32'h00000000;
    hit_next = 1'b1;
    ridx = 8'h00;
    if (idx >= `WOL_IDX_CRC_BASE && idx < `WOL_IDX_MASK_BASE) begin
      ridx = idx - `WOL_IDX_CRC_BASE;
      rdata_next = {16'h0000, crc_reg[ridx[2:0]]};
    end else if (idx >= `WOL_IDX_MASK_BASE && idx < `WOL_IDX_CTRL_STAT) begin
      ridx = idx - `WOL_IDX_MASK_BASE;
      rdata_next = {16'h0000, mask_reg[ridx[3:0]]};
    end else if (idx >= `WOL_IDX_RXCRC_BASE && idx < 8'h38) begin
      ridx = idx - `WOL_IDX_RXCRC_BASE;
      rdata_next = ridx[0] ? {16'h0000, rxcrc_reg[ridx[2:1]][31:16]} :
                   {16'h0000, rxcrc_reg[ridx[2:1]][15:0]};
    end else begin
      case (idx)
        `WOL_IDX_ROUTE: rdata_next = {16'h0000, route_reg};
        `WOL_IDX_CTRL: rdata_next = {16'h0000, ctrl_reg};
        `WOL_IDX_MAC_LO: rdata_next = {16'h0000, mac_lo_reg};
        `WOL_IDX_MAC_MI: rdata_next = {16'h0000, mac_mi_reg};
        `WOL_IDX_MAC_HI: rdata_next = {16'h0000, mac_hi_reg};
        `WOL_IDX_CTRL_STAT: rdata_next = {31'h00000000, any_pend};
        `WOL_IDX_CUST_STAT: rdata_next = {28'h0000000, cust_pend_reg};
        `WOL_IDX_MAGIC_STAT: rdata_next = {31'h00000000, magic_pend_reg};
        `WOL_IDX_LINK_STAT: rdata_next = {29'h00000000, link_s2_reg, ldn_pend_reg,
                                          lup_pend_reg};
        `WOL_IDX_MISC: rdata_next = {16'h0000, misc_reg};
        default: hit_next = 1'b0;
      endcase
    end
  end

  assign mapped = hit_next;
  assign pslverr = psel & penable & ~mapped;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_rd) begin
      prdata <= rdata_next;
    end
  end

  integer k;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 16'h0000;
      route_reg <= 16'h0000;
      misc_reg <= 16'h0000;
      mac_lo_reg <= 16'h0000;
      mac_mi_reg <= 16'h0000;
      mac_hi_reg <= 16'h0000;
      for (k = 0; k < 2 * NUM_CUST; k = k + 1) begin
        crc_reg[k] <= 16'h0000;
      end
      for (k = 0; k < 4 * NUM_CUST; k = k + 1) begin
        mask_reg[k] <= 16'h0000;
      end
    end else if (wr_acc) begin
      if (idx >= `WOL_IDX_CRC_BASE && idx < `WOL_IDX_MASK_BASE) begin
        crc_reg[ridx[2:0]] <= pwdata[15:0];
      end else if (idx >= `WOL_IDX_MASK_BASE && idx < `WOL_IDX_CTRL_STAT) begin
        mask_reg[ridx[3:0]] <= pwdata[15:0];
      end else begin
        case (idx)
          `WOL_IDX_ROUTE: route_reg <= pwdata[15:0];
          `WOL_IDX_CTRL: ctrl_reg <= pwdata[15:0];
          `WOL_IDX_MAC_LO: mac_lo_reg <= pwdata[15:0];
          `WOL_IDX_MAC_MI: mac_mi_reg <= pwdata[15:0];
          `WOL_IDX_MAC_HI: mac_hi_reg <= pwdata[15:0];
          `WOL_IDX_MISC: misc_reg <= pwdata[15:0];
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  // Link level is synchronised before edge detection.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_s1_reg <= 1'b0;
      link_s2_reg <= 1'b0;
      link_s3_reg <= 1'b0;
    end else begin
      link_s1_reg <= link_up_pin;
      link_s2_reg <= link_s1_reg;
      link_s3_reg <= link_s2_reg;
    end
  end

  // Only the receive stream is matched.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff_cnt_reg <= 3'h0;
      mac_idx_reg <= 7'h00;
      mac_pos_reg <= 3'h0;
      magic_hit_reg <= 1'b0;
    end else if (rx_valid) begin
      if (rx_sof) begin
        magic_hit_reg <= 1'b0;
      end
      if (rx_eof) begin
        ff_cnt_reg <= 3'h0;
        mac_idx_reg <= 7'h00;
        mac_pos_reg <= 3'h0;
      end else if (mac_idx_reg != 7'h00) begin
        if (rx_data == wol_mac_byte(mac, mac_pos_reg)) begin
          if (mac_idx_reg == `WOL_MAC_COPIES - 7'h01) begin
            magic_hit_reg <= 1'b1;
            mac_idx_reg <= 7'h00;
            ff_cnt_reg <= 3'h0;
          end else begin
            mac_idx_reg <= mac_idx_reg + 7'h01;
          end
          mac_pos_reg <= (mac_pos_reg == 3'h5) ? 3'h0 : mac_pos_reg + 3'h1;
        end else begin
          mac_idx_reg <= 7'h00;
          mac_pos_reg <= 3'h0;
          ff_cnt_reg <= (rx_data == 8'hFF) ? 3'h1 : 3'h0;
        end
      end else if (ff_cnt_reg == `WOL_PRE_BYTES && rx_data == wol_mac_byte(mac, 3'h0)) begin
        mac_idx_reg <= 7'h01;
        mac_pos_reg <= 3'h1;
      end else if (rx_data == 8'hFF) begin
        if (ff_cnt_reg != `WOL_PRE_BYTES) begin
          ff_cnt_reg <= ff_cnt_reg + 3'h1;
        end
      end else begin
        ff_cnt_reg <= 3'h0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_cnt_reg <= 7'h00;
    end else if (rx_valid) begin
      byte_cnt_reg <= (rx_eof || cur_cnt == `WOL_CUST_BYTES) ? cur_cnt : cur_cnt + 7'h01;
    end
  end

  // One matcher per custom frame type.
  genvar g;
  generate
    for (g = 0; g < NUM_CUST; g = g + 1) begin : g_cust
      wire [63:0] msk;
      wire [31:0] acc;
      wire [31:0] acc_new;
      wire sel;
      assign msk = {mask_reg[4*g+3], mask_reg[4*g+2], mask_reg[4*g+1], mask_reg[4*g]};
      assign acc = rx_sof ? `WOL_CRC_INIT : crc_acc_reg[g];
      assign sel = (cur_cnt < `WOL_CUST_BYTES) && msk[cur_cnt[5:0]];
      assign acc_new = sel ? wol_crc_byte(acc, rx_data) : acc;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          crc_acc_reg[g] <= `WOL_CRC_INIT;
          rxcrc_reg[g] <= 32'h00000000;
          cust_pend_reg[g] <= 1'b0;
        end else begin
          if (rx_valid) begin
            crc_acc_reg[g] <= acc_new;
          end
          if (rx_valid && rx_eof && !rx_err) begin
            rxcrc_reg[g] <= ~acc_new;
          end
          if (!ctrl_reg[`WOL_CTRL_CUST_LSB + g]) begin
            cust_pend_reg[g] <= 1'b0;
          end else if (rx_valid && rx_eof && !rx_err &&
                       ~acc_new == {crc_reg[2*g+1], crc_reg[2*g]}) begin
            cust_pend_reg[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      magic_pend_reg <= 1'b0;
      lup_pend_reg <= 1'b0;
      ldn_pend_reg <= 1'b0;
    end else begin
      if (!ctrl_reg[`WOL_CTRL_MAGIC]) begin
        magic_pend_reg <= 1'b0;
      end else if (rx_valid && rx_eof && !rx_err && magic_hit_reg) begin
        magic_pend_reg <= 1'b1;
      end
      if (!ctrl_reg[`WOL_CTRL_LUP]) begin
        lup_pend_reg <= 1'b0;
      end else if (link_s2_reg && !link_s3_reg) begin
        lup_pend_reg <= 1'b1;
      end
      if (!ctrl_reg[`WOL_CTRL_LDN]) begin
        ldn_pend_reg <= 1'b0;
      end else if (!link_s2_reg && link_s3_reg) begin
        ldn_pend_reg <= 1'b1;
      end
    end
  end

  assign any_pend = magic_pend_reg | lup_pend_reg | ldn_pend_reg | (|cust_pend_reg);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_out_on_led_pin_n <= 1'b1;
      wake_out_on_led_pin_oe <= 1'b0;
      wake_out_on_irq_pin <= 1'b1;
      wake_out_on_irq_pin_oe <= 1'b0;
    end else begin
      wake_out_on_led_pin_n <= ~(any_pend & ctrl_reg[`WOL_CTRL_OSEL_LSB]);
      wake_out_on_led_pin_oe <= route_reg[`WOL_ROUTE_LED];
      wake_out_on_irq_pin <= ~(any_pend & ctrl_reg[`WOL_CTRL_OSEL_LSB + 1]) ^
                             misc_reg[`WOL_MISC_IRQ_INV];
      wake_out_on_irq_pin_oe <= route_reg[`WOL_ROUTE_IRQ];
    end
  end

endmodule // wol_detector

// ==== wol_asserts.sv ====
`timescale 1ns/1ps
`include "wol_map.vh"
module wol_asserts (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rx_valid,
  input wire rx_eof,
  input wire link_up_pin,
  input wire wake_out_on_led_pin_n,
  input wire wake_out_on_led_pin_oe,
  input wire wake_out_on_irq_pin
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wr_ctrl = acc && pwrite && paddr == {`WOL_IDX_CTRL, 2'b00};
  wire wr_route = acc && pwrite && paddr == {`WOL_IDX_ROUTE, 2'b00};
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  a_ready_access: assert property (s_setup ##1 s_access |-> pready)
    else $error("access phase without ready");
  a_err_access: assert property (pslverr |-> acc)
    else $error("slave error outside access");
  a_err_unmapped: assert property (acc && paddr == 10'h3FC |-> pslverr)
    else $error("unmapped access not refused");
  a_rd_latched: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("read data moved outside read setup");
  a_pins_reset: assert property ($rose(presetn) |->
    wake_out_on_led_pin_n && wake_out_on_irq_pin && !wake_out_on_led_pin_oe)
    else $error("wake pins not idle after reset");
  a_wake_cause: assert property ($fell(wake_out_on_led_pin_n) |->
    $past(rx_valid && rx_eof, 2) || $past(link_up_pin, 3) != $past(link_up_pin, 7))
    else $error("wake without frame end or link change");
  a_wake_release: assert property ($rose(wake_out_on_led_pin_n) |->
    $past(wr_ctrl, 1) || $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
    else $error("wake released without control write");
  a_oe_route: assert property ($changed(wake_out_on_led_pin_oe) |->
    $past(wr_route, 1) || $past(wr_route, 2))
    else $error("pin enable moved without route write");
endmodule // wol_asserts
bind wol_detector wol_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_valid(rx_valid), .rx_eof(rx_eof), .link_up_pin(link_up_pin),
  .wake_out_on_led_pin_n(wake_out_on_led_pin_n),
  .wake_out_on_led_pin_oe(wake_out_on_led_pin_oe), .wake_out_on_irq_pin(wake_out_on_irq_pin));

// ==== wol_frame_src.sv ====
`timescale 1ns/1ps
module wol_frame_src (
  input wire pclk,
  output logic rx_valid,
  output logic rx_sof,
  output logic rx_eof,
  output logic rx_err,
  output logic [7:0] rx_data,
  output logic link_up_pin
);
  logic [7:0] q[$];
  initial {rx_valid, rx_sof, rx_eof, rx_err, rx_data, link_up_pin} = 13'h0000;
  task automatic send(input bit err);
    int n;
    n = q.size();
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      {rx_valid, rx_sof, rx_eof, rx_err, rx_data} <= {1'b1, i == 0, i == n - 1, err && i == n - 1, q[i]};
    end
    @(posedge pclk);
    {rx_valid, rx_sof, rx_eof, rx_err, rx_data} <= {4'h0, ~rx_data};
    q.delete();
  endtask
  task automatic set_link(input bit v);
    @(posedge pclk);
    link_up_pin <= v;
  endtask
endmodule // wol_frame_src

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "wol_map.vh"
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, r, c;
  wire [31:0] prdata;
  wire [7:0] rx_data;
  wire pready, pslverr, rx_valid, rx_sof, rx_eof, rx_err, link_up_pin, led, led_oe, irq, irq_oe;
  int error_cnt = 0, cmp_count = 0;
  localparam logic [47:0] MAC = 48'h0123456789AB;
  always #2.5 pclk = ~pclk;
  wol_detector dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_err(rx_err),
    .rx_data(rx_data), .link_up_pin(link_up_pin), .wake_out_on_led_pin_n(led),
    .wake_out_on_led_pin_oe(led_oe), .wake_out_on_irq_pin(irq), .wake_out_on_irq_pin_oe(irq_oe));
  wol_frame_src src (.pclk(pclk), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .rx_err(rx_err), .rx_data(rx_data), .link_up_pin(link_up_pin));
  task automatic stop_test();
    $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, i, 2'b00, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 20) begin
      error_cnt++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask
  task automatic rc(input string n, input logic [7:0] i, input logic [31:0] x);
    apb(1'b0, i, 32'h0);
    chk(n, x, r);
  endtask
  task automatic pins(input logic [1:0] x, input int t);
    repeat (t) @(posedge pclk);
    chk("pins", {30'h0, x}, {30'h0, led, irq});
  endtask
  task automatic magic(input bit err);
    src.q.push_back(8'h11);
    for (int i = 0; i < 8; i++) src.q.push_back(i < 6 ? 8'hFF : MAC[47 - 8 * (i - 6) -: 8]);
    src.q.push_back(8'h00);
    for (int i = 0; i < 6; i++) src.q.push_back(8'hFF);
    for (int i = 0; i < 96; i++) src.q.push_back(MAC[47 - 8 * (i % 6) -: 8]);
    src.q.push_back(8'h22);
    src.send(err);
  endtask
  task automatic frm(input logic [31:0] w, input bit err);
    for (int i = 0; i < 4; i++) src.q.push_back(w[31 - 8 * i -: 8]);
    src.q.push_back(8'h77);
    src.q.push_back(8'h88);
    src.send(err);
  endtask
  function automatic logic [31:0] crc(input logic [31:0] w);
    logic [31:0] v;
    v = 32'hFFFFFFFF;
    for (int i = 0; i < 4; i++) begin
      v = v ^ {24'h0, w[31 - 8 * i -: 8]};
      for (int j = 0; j < 8; j++) v = v[0] ? (v >> 1) ^ 32'hEDB88320 : v >> 1;
    end
    return ~v;
  endfunction
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("reset pins", 32'hA, {28'h0, led, led_oe, irq, irq_oe});
    rc("ctrl", `WOL_IDX_CTRL, 32'h0);
    apb(1'b0, 8'hFF, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    wr(`WOL_IDX_MAC_LO, 32'h89AB);
    wr(`WOL_IDX_MAC_MI, 32'h4567);
    wr(`WOL_IDX_MAC_HI, 32'h0123);
    rc("mac mid", `WOL_IDX_MAC_MI, 32'h4567);
    wr(`WOL_IDX_ROUTE, 32'h3);
    wr(`WOL_IDX_CTRL, 32'hC000);
    pins(2'b11, 2);
    chk("oe", 32'h3, {30'h0, led_oe, irq_oe});
    magic(1'b0);
    pins(2'b11, 3);
    wr(`WOL_IDX_CTRL, 32'hC040);
    magic(1'b1);
    pins(2'b11, 3);
    magic(1'b0);
    pins(2'b00, 3);
    rc("magic stat", `WOL_IDX_MAGIC_STAT, 32'h1);
    rc("any pending", `WOL_IDX_CTRL_STAT, 32'h1);
    wr(`WOL_IDX_CTRL, 32'hC000);
    pins(2'b11, 3);
    $display("Magic frame tests finished");
    for (int k = 0; k < 4; k++) begin
      c = crc({k[7:0], 24'h5AC33C});
      wr(8'(`WOL_IDX_MASK_BASE + 4 * k), 32'h000F);
      wr(8'(`WOL_IDX_CRC_BASE + 2 * k), {16'h0, c[15:0]});
      wr(8'(`WOL_IDX_CRC_BASE + 2 * k + 1), {16'h0, c[31:16]});
      wr(`WOL_IDX_CTRL, 32'hC000 | (32'h4 << k));
      frm({k[7:0] ^ 8'h80, 24'h5AC33C}, 1'b0);
      pins(2'b11, 3);
      frm({k[7:0], 24'h5AC33C}, 1'b1);
      pins(2'b11, 3);
      frm({k[7:0], 24'h5AC33C}, 1'b0);
      pins(2'b00, 3);
      rc("cust stat", `WOL_IDX_CUST_STAT, 32'h1 << k);
      rc("rx crc lo", 8'(`WOL_IDX_RXCRC_BASE + 2 * k), {16'h0, c[15:0]});
      rc("rx crc hi", 8'(`WOL_IDX_RXCRC_BASE + 2 * k + 1), {16'h0, c[31:16]});
      wr(`WOL_IDX_CTRL, 32'hC000);
      pins(2'b11, 3);
    end
    $display("Custom frame tests finished");
    for (int u = 0; u < 2; u++) begin
      wr(`WOL_IDX_CTRL, 32'hC000 | (32'h1 << u));
      src.set_link(u == 0);
      pins(2'b00, 6);
      rc("link stat", `WOL_IDX_LINK_STAT, u == 0 ? 32'h5 : 32'h2);
      wr(`WOL_IDX_CTRL, 32'hC000);
      pins(2'b11, 3);
    end
    wr(`WOL_IDX_MISC, 32'h1);
    pins(2'b10, 3);
    $display("Link and polarity tests finished");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("mid reset pins", 32'hA, {28'h0, led, led_oe, irq, irq_oe});
    rc("ctrl after reset", `WOL_IDX_CTRL, 32'h0);
    rc("route after reset", `WOL_IDX_ROUTE, 32'h0);
    rc("misc after reset", `WOL_IDX_MISC, 32'h0);
    $display("Reset tests finished");
    stop_test();
  end
endmodule // testbench
